// [logic/mcu_interrupt_logic.sv]
// Interrupt controller of a small 8-bit core, reached over APB.
// Assumes the core reports sleep and return-from-interrupt execution as one-clock pulses
// and performs the vector jump and stack push when vectorStrobe is seen.
`timescale 1ns/10ps
module mcu_interrupt_logic (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt sources
    input wire logic extIrqPin,
    input wire logic [3:0] upperPortPins,
    input wire logic [7:0] timer0Count,
    input wire logic eepromWriteDone,
    // Core sequencer
    input wire logic sleepExec,
    input wire logic retfieExec,
    output logic vectorStrobe,
    output logic [12:0] vectorAddr,
    output logic coreAsleep,
    output logic wakeStrobe,
    output logic sleepNop,
    // Interrupt to system
    output logic irqOut
);
    logic instrTick;
    logic [7:0] irqControl_r;
    logic [7:0] optionConfig_r;
    logic eeFlag_r;
    logic eeEnable_r;
    logic [mcu_irq_pkg::EVT_WIDTH-1:0] evtStatus_r;
    logic [mcu_irq_pkg::EVT_WIDTH-1:0] evtMask_r;
    logic extSync_r;
    logic extPrev_r;
    logic [3:0] portSync_r;
    logic [3:0] portLatch_r;
    logic [7:0] timerPrev_r;
    logic srcArmed_r;
    logic pending_r;
    logic wakeHold_r;
    logic [2:0] sleepEnables_r;
    logic wrAccess;
    logic rdAccess;
    logic extEdge;
    logic portChange;
    logic timerRoll;
    logic anyEnabledFlag;
    logic wakeCond;
    logic vectorGo;
    logic [31:0] rdMux;
    logic rdHit;

    instr_cycle_divider #(
        .DIV(mcu_irq_pkg::INSTR_CLKS)
    ) u_div (
        .clk(clk),
        .arst_n(arst_n),
        .tick(instrTick)
    );

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    // APB: one wait state, access completes on the edge where pready is seen
    assign wrAccess = psel && penable && pready && pwrite;
    assign rdAccess = psel && penable && !pready;

    always_comb
    begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        unique case (1'b1)
            hit(paddr, mcu_irq_pkg::OFS_IRQ_CONTROL): rdMux[7:0] = irqControl_r;
            hit(paddr, mcu_irq_pkg::OFS_OPTION_CONFIG): rdMux[7:0] = optionConfig_r;
            hit(paddr, mcu_irq_pkg::OFS_EEPROM_IRQ): rdMux[1:0] = {eeEnable_r, eeFlag_r};
            hit(paddr, mcu_irq_pkg::OFS_EVENT_STATUS): rdMux[mcu_irq_pkg::EVT_WIDTH-1:0] = evtStatus_r;
            hit(paddr, mcu_irq_pkg::OFS_EVENT_MASK): rdMux[mcu_irq_pkg::EVT_WIDTH-1:0] = evtMask_r;
            hit(paddr, mcu_irq_pkg::OFS_CORE_STATE): rdMux[1:0] = {pending_r, coreAsleep};
            default: rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= rdAccess;
            pslverr <= rdAccess && !rdHit;
            if (rdAccess)
                prdata <= (rdHit && !pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    // Source detection; pin and port sampled once per instruction cycle, timer compared every clock
    assign extEdge = srcArmed_r && (optionConfig_r[mcu_irq_pkg::BIT_EXT_EDGE] ? (extSync_r && !extPrev_r)
        : (!extSync_r && extPrev_r));
    assign portChange = srcArmed_r && (portSync_r != portLatch_r);
    assign timerRoll = (timerPrev_r == mcu_irq_pkg::TIMER_TOP) && (timer0Count == mcu_irq_pkg::TIMER_ZERO);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            extSync_r <= 1'b0;
            extPrev_r <= 1'b0;
            portSync_r <= 4'h0;
            portLatch_r <= 4'h0;
        end
        else if (instrTick)
        begin
            // Two-stage sampling gives the three-to-four cycle entry latency
            extSync_r <= extIrqPin;
            extPrev_r <= srcArmed_r ? extSync_r : extIrqPin;
            portSync_r <= upperPortPins;
            portLatch_r <= srcArmed_r ? portSync_r : upperPortPins;
        end
    end

    // First sample loads both stages, so the pin level after reset is no event
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            srcArmed_r <= 1'b0;
        else if (instrTick)
            srcArmed_r <= 1'b1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            timerPrev_r <= mcu_irq_pkg::TIMER_ZERO;
        else
            timerPrev_r <= timer0Count;
    end

    assign anyEnabledFlag = |(irqControl_r[2:0] & irqControl_r[5:3]) || (eeFlag_r && eeEnable_r);
    assign vectorGo = instrTick && pending_r && irqControl_r[mcu_irq_pkg::BIT_GIE] && !coreAsleep
        && !wakeHold_r && !wakeStrobe && !vectorStrobe;

    // irq_control_reg: hardware set wins over a software clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            irqControl_r <= mcu_irq_pkg::IRQ_CONTROL_RST;
        else
        begin
            if (wrAccess && hit(paddr, mcu_irq_pkg::OFS_IRQ_CONTROL))
                irqControl_r <= pwdata[7:0] & mcu_irq_pkg::IRQ_CONTROL_MASK;
            if (retfieExec)
                irqControl_r[mcu_irq_pkg::BIT_GIE] <= 1'b1;
            if (vectorGo)
                irqControl_r[mcu_irq_pkg::BIT_GIE] <= 1'b0;
            if (instrTick && extEdge)
                irqControl_r[mcu_irq_pkg::BIT_EXT_FLAG] <= 1'b1;
            if (instrTick && portChange)
                irqControl_r[mcu_irq_pkg::BIT_PORT_FLAG] <= 1'b1;
            if (timerRoll)
                irqControl_r[mcu_irq_pkg::BIT_TMR_FLAG] <= 1'b1;
        end
    end

    // Other registers of the map
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            optionConfig_r <= mcu_irq_pkg::OPTION_CONFIG_RST;
            eeFlag_r <= 1'b0;
            eeEnable_r <= 1'b0;
            evtMask_r <= mcu_irq_pkg::EVENT_MASK_RST;
        end
        else
        begin
            if (wrAccess && hit(paddr, mcu_irq_pkg::OFS_OPTION_CONFIG))
                optionConfig_r <= pwdata[7:0];
            if (wrAccess && hit(paddr, mcu_irq_pkg::OFS_EVENT_MASK))
                evtMask_r <= pwdata[mcu_irq_pkg::EVT_WIDTH-1:0];
            if (wrAccess && hit(paddr, mcu_irq_pkg::OFS_EEPROM_IRQ))
            begin
                eeFlag_r <= pwdata[mcu_irq_pkg::BIT_EE_FLAG];
                eeEnable_r <= pwdata[mcu_irq_pkg::BIT_EE_EN];
            end
            if (eepromWriteDone)
                eeFlag_r <= 1'b1;
        end
    end

    // Request pending: any flag whose own enable is set
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pending_r <= 1'b0;
        else if (instrTick)
            pending_r <= anyEnabledFlag;
    end

    // Vector entry; the core pushes only the return address on this pulse
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vectorStrobe <= 1'b0;
            vectorAddr <= mcu_irq_pkg::VECTOR_ADDR;
        end
        else
        begin
            vectorStrobe <= vectorGo;
            vectorAddr <= mcu_irq_pkg::VECTOR_ADDR;
        end
    end

    // Sleep and wake; the timer cannot run asleep so it does not wake the core
    assign wakeCond = |(sleepEnables_r & {eeFlag_r, irqControl_r[mcu_irq_pkg::BIT_EXT_FLAG],
        irqControl_r[mcu_irq_pkg::BIT_PORT_FLAG]});

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            coreAsleep <= 1'b0;
            wakeStrobe <= 1'b0;
            sleepNop <= 1'b0;
            sleepEnables_r <= 3'h0;
        end
        else
        begin
            wakeStrobe <= 1'b0;
            sleepNop <= 1'b0;
            if (sleepExec && !coreAsleep)
            begin
                if (anyEnabledFlag)
                    sleepNop <= 1'b1;
                else
                begin
                    coreAsleep <= 1'b1;
                    sleepEnables_r <= {eeEnable_r, irqControl_r[mcu_irq_pkg::BIT_EXT_EN],
                        irqControl_r[mcu_irq_pkg::BIT_PORT_EN]};
                end
            end
            else if (coreAsleep && wakeCond)
            begin
                coreAsleep <= 1'b0;
                wakeStrobe <= 1'b1;
            end
        end
    end

    // After a wake the next instruction runs before any vectoring
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wakeHold_r <= 1'b0;
        else if (wakeStrobe)
            wakeHold_r <= 1'b1;
        else if (instrTick)
            wakeHold_r <= 1'b0;
    end

    // Event status (write one to clear, set wins) and interrupt output
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            evtStatus_r <= '0;
        else
        begin
            if (wrAccess && hit(paddr, mcu_irq_pkg::OFS_EVENT_STATUS))
                evtStatus_r <= evtStatus_r & ~pwdata[mcu_irq_pkg::EVT_WIDTH-1:0];
            if (vectorStrobe)
                evtStatus_r[mcu_irq_pkg::EVT_VECTOR] <= 1'b1;
            if (wakeStrobe)
                evtStatus_r[mcu_irq_pkg::EVT_WAKE] <= 1'b1;
            if (sleepNop)
                evtStatus_r[mcu_irq_pkg::EVT_SLEEP_NOP] <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            irqOut <= 1'b0;
        else
            irqOut <= |(evtStatus_r & evtMask_r);
    end

    // Checks
    sequence s_sleep_with_flag;
        sleepExec && !coreAsleep && anyEnabledFlag;
    endsequence

    sequence s_nop_result;
        sleepNop && !coreAsleep;
    endsequence

    a_vector_clears_gie: assert property (@(posedge clk) disable iff (!arst_n)
        vectorGo && !retfieExec |=> vectorStrobe && !irqControl_r[mcu_irq_pkg::BIT_GIE])
        else $error("vector entry did not clear global enable");

    a_return_from_irq_instr_sets_gie: assert property (@(posedge clk) disable iff (!arst_n)
        retfieExec && !vectorGo |=> irqControl_r[mcu_irq_pkg::BIT_GIE])
        else $error("return did not set global enable");

    a_no_vector_gie: assert property (@(posedge clk) disable iff (!arst_n)
        vectorStrobe |-> $past(irqControl_r[mcu_irq_pkg::BIT_GIE]) && !$past(coreAsleep))
        else $error("vector issued with servicing disabled");

    a_ext_edge_flag: assert property (@(posedge clk) disable iff (!arst_n)
        instrTick && extEdge |=> irqControl_r[mcu_irq_pkg::BIT_EXT_FLAG])
        else $error("pin edge did not set its flag");

    a_timer_roll_flag: assert property (@(posedge clk) disable iff (!arst_n)
        timerRoll |=> irqControl_r[mcu_irq_pkg::BIT_TMR_FLAG])
        else $error("timer rollover did not set its flag");

    a_port_change_flag: assert property (@(posedge clk) disable iff (!arst_n)
        instrTick && portChange |=> irqControl_r[mcu_irq_pkg::BIT_PORT_FLAG])
        else $error("port change did not set its flag");

    a_sleep_nop_path: assert property (@(posedge clk) disable iff (!arst_n)
        s_sleep_with_flag |=> s_nop_result)
        else $error("sleep with pending flag did not act as no-op");

    a_wake_enabled: assert property (@(posedge clk) disable iff (!arst_n)
        coreAsleep && wakeCond && !sleepExec |=> wakeStrobe && !coreAsleep ##1 !vectorStrobe[*3])
        else $error("enabled source did not wake, or vectored too early");

    a_vector_latency: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(irqControl_r[mcu_irq_pkg::BIT_EXT_FLAG]) && irqControl_r[mcu_irq_pkg::BIT_EXT_EN]
        && irqControl_r[mcu_irq_pkg::BIT_GIE] && !coreAsleep && !wakeHold_r && !wakeStrobe
        |-> ##[1:8] vectorStrobe)
        else $error("enabled pin request not vectored in time");

    a_irq_out_level: assert property (@(posedge clk) disable iff (!arst_n)
        irqOut == $past(|(evtStatus_r & evtMask_r)))
        else $error("interrupt output does not follow masked status");
endmodule : mcu_interrupt_logic

// [shared/mcu_irq_pkg.sv]
// Constants for the interrupt logic block: register map, bit positions, reset values.
// Assumes a 20 MHz clock and a four-clock instruction cycle.
// What this block does
// - Four sources: pin, timer, port, EEPROM
// - Pin, timer, port flags and enables, global enable in control
// - Global enable bit 7 gates all servicing
// - Reset clears the global enable
// - Return-from-interrupt sets the global enable
// - Vector entry clears global enable, pushes, 0004h
// - Pin/port latency three to four cycles
// - Flags set regardless of any enable
// - Pin edge chosen by option bit 6
// - Pin edge sets bit 1, enable bit 4
// - Pin wakes only if enabled before sleep
// - Timer FFh to 00h sets bit 2, enable 5
// - Port pins 7:4 change sets bit 0, enable 3
// - Only return address saved on entry
// - Enabled pin, port or EEPROM source wakes; global enable decides vectoring
// - Sleep with enabled flag set acts as no-op
package mcu_irq_pkg;
    localparam int INSTR_CLKS = 4;
    localparam logic [12:0] VECTOR_ADDR = 13'h0004;
    localparam logic [7:0] TIMER_TOP = 8'hFF;
    localparam logic [7:0] TIMER_ZERO = 8'h00;

    // APB byte offsets
    localparam logic [7:0] OFS_IRQ_CONTROL = 8'h00;
    localparam logic [7:0] OFS_OPTION_CONFIG = 8'h04;
    localparam logic [7:0] OFS_EEPROM_IRQ = 8'h08;
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h0C;
    localparam logic [7:0] OFS_EVENT_MASK = 8'h10;
    localparam logic [7:0] OFS_CORE_STATE = 8'h14;

    // irq_control_reg fields
    localparam int BIT_PORT_FLAG = 0;
    localparam int BIT_EXT_FLAG = 1;
    localparam int BIT_TMR_FLAG = 2;
    localparam int BIT_PORT_EN = 3;
    localparam int BIT_EXT_EN = 4;
    localparam int BIT_TMR_EN = 5;
    localparam int BIT_GIE = 7;
    localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;
    localparam logic [7:0] IRQ_CONTROL_MASK = 8'hBF;

    // option_config_reg
    localparam int BIT_EXT_EDGE = 6;
    localparam logic [7:0] OPTION_CONFIG_RST = 8'hFF;

    // EEPROM source register
    localparam int BIT_EE_FLAG = 0;
    localparam int BIT_EE_EN = 1;

    // Event status / mask
    localparam int EVT_WIDTH = 3;
    localparam int EVT_VECTOR = 0;
    localparam int EVT_WAKE = 1;
    localparam int EVT_SLEEP_NOP = 2;
    localparam logic [EVT_WIDTH-1:0] EVENT_MASK_RST = 3'h0;
endpackage : mcu_irq_pkg

// [logic/instr_cycle_divider.sv]
// Instruction-cycle enable generator.
// Assumes one free-running clock; emits a one-clock pulse every DIV clocks.
`timescale 1ns/10ps
module instr_cycle_divider #(
    parameter int DIV = mcu_irq_pkg::INSTR_CLKS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Enable pulse
    output logic tick
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] count_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_r <= '0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (count_r == LAST);
            count_r <= (count_r == LAST) ? '0 : count_r + CW'(1);
        end
    end

    a_tick_spacing: assert property (@(posedge clk) disable iff (!arst_n)
        tick |=> !tick) else $error("tick lasted more than one clock");
endmodule : instr_cycle_divider

// [bench/core_model.sv]
// Behavioural core sequencer facing the interrupt logic.
// Assumes one clock; the bench asks for sleep and return instructions by level requests.
`timescale 1ns/10ps
module core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // From interrupt logic
    input wire logic vectorStrobe,
    input wire logic [12:0] vectorAddr,
    // Bench requests
    input wire logic goSleep,
    input wire logic goRetfie,
    // To interrupt logic
    output logic sleepExec,
    output logic retfieExec,
    // Observed state
    output logic [12:0] pc,
    output logic [3:0] depth
);
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sleepExec <= 1'b0;
            retfieExec <= 1'b0;
            pc <= 13'h0000;
            depth <= 4'h0;
        end
        else
        begin
            sleepExec <= goSleep;
            // Only a routine that was entered can be left
            retfieExec <= goRetfie && depth != 4'h0;
            if (vectorStrobe)
            begin
                // Only the return address goes on the stack
                depth <= depth + 4'h1;
                pc <= vectorAddr;
            end
            else if (retfieExec)
                depth <= depth - 4'h1;
        end
    end
endmodule : core_model

// [bench/testbench.sv]
// Self-checking bench for the interrupt logic with an APB master and a core model.
// Assumes the register offsets and one-wait-state APB of the design package.
`timescale 1ns/10ps
module testbench;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
    logic clk = 1'b0, arstN = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic extIrqPin = 1'b1, eepromWriteDone = 1'b0, goSleep = 1'b0, goRetfie = 1'b0;
    logic [3:0] upperPortPins = 4'h0, depth;
    logic [7:0] timer0Count = 8'h10;
    logic sleepExec, retfieExec, vectorStrobe, coreAsleep, wakeStrobe, sleepNop, irqOut;
    logic [12:0] vectorAddr, pc;
    int errors = 0, total_checks = 0, vecCnt = 0, wakeCnt = 0, nopCnt = 0, n;
    row_s rows[4] = '{'{8'h04, 32'h40, 32'h40}, '{8'h08, 32'h02, 32'h02},
        '{8'h10, 32'h07, 32'h07}, '{8'h00, 32'h78, 32'h38}};

    always #25 clk = ~clk;

    mcu_interrupt_logic dut (.clk(clk), .arst_n(arstN), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .extIrqPin(extIrqPin), .upperPortPins(upperPortPins), .timer0Count(timer0Count),
        .eepromWriteDone(eepromWriteDone), .sleepExec(sleepExec), .retfieExec(retfieExec),
        .vectorStrobe(vectorStrobe), .vectorAddr(vectorAddr), .coreAsleep(coreAsleep),
        .wakeStrobe(wakeStrobe), .sleepNop(sleepNop), .irqOut(irqOut));
    core_model core (.clk(clk), .arst_n(arstN), .vectorStrobe(vectorStrobe), .vectorAddr(vectorAddr),
        .goSleep(goSleep), .goRetfie(goRetfie), .sleepExec(sleepExec), .retfieExec(retfieExec),
        .pc(pc), .depth(depth));

    always @(posedge clk)
    begin
        vecCnt <= vecCnt + (vectorStrobe === 1'b1);
        wakeCnt <= wakeCnt + (wakeStrobe === 1'b1);
        nopCnt <= nopCnt + (sleepNop === 1'b1);
    end

    task final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk

    task chkFlag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chkFlag

    task tick(input int c);
        repeat (c) @(posedge clk);
    endtask : tick

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            errors++;
            $display("BAD %0t bus transfer not answered", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk

    task pulse(input int which);
        @(posedge clk);
        case (which)
            0: eepromWriteDone <= 1'b1;
            1: goSleep <= 1'b1;
            default: goRetfie <= 1'b1;
        endcase
        @(posedge clk);
        eepromWriteDone <= 1'b0;
        goSleep <= 1'b0;
        goRetfie <= 1'b0;
        tick(4);
    endtask : pulse

    task overflow;
        @(posedge clk);
        timer0Count <= 8'hFF;
        @(posedge clk);
        timer0Count <= 8'h00;
        tick(4);
    endtask : overflow

    initial
    begin
        tick(2);
        arstN <= 1'b1;
        rdchk(8'h00, 32'h00);
        rdchk(8'h04, 32'hFF);
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].d);
            rdchk(rows[i].a, rows[i].e);
        end
        overflow();
        rdchk(8'h00, 32'h3C);
        @(posedge clk) upperPortPins <= 4'h5;
        tick(20);
        rdchk(8'h00, 32'h3D);
        @(posedge clk) extIrqPin <= 1'b0;
        tick(20);
        rdchk(8'h00, 32'h3D);
        @(posedge clk) extIrqPin <= 1'b1;
        tick(20);
        rdchk(8'h00, 32'h3F);
        pulse(0);
        rdchk(8'h08, 32'h03);
        chk(vecCnt, 0);
        pulse(1);
        chk(nopCnt, 1);
        chkFlag(coreAsleep, 1'b0);
        apb(1'b1, 8'h00, 32'h38);
        apb(1'b1, 8'h08, 32'h02);
        pulse(1);
        chkFlag(coreAsleep, 1'b1);
        pulse(0);
        chk(wakeCnt, 1);
        chkFlag(coreAsleep, 1'b0);
        apb(1'b1, 8'h00, 32'hB8);
        tick(20);
        chk(vecCnt, 1);
        chk(pc, 13'h0004);
        rdchk(8'h00, 32'h38);
        rdchk(8'h0C, 32'h07);
        chkFlag(irqOut, 1'b1);
        apb(1'b1, 8'h10, 32'h00);
        tick(3);
        chkFlag(irqOut, 1'b0);
        apb(1'b1, 8'h10, 32'h07);
        apb(1'b1, 8'h0C, 32'h07);
        tick(3);
        chkFlag(irqOut, 1'b0);
        rdchk(8'h0C, 32'h00);
        apb(1'b1, 8'h08, 32'h02);
        pulse(2);
        rdchk(8'h00, 32'hB8);
        overflow();
        tick(20);
        chk(vecCnt, 2);
        apb(1'b1, 8'h00, 32'h38);
        pulse(2);
        @(posedge clk) extIrqPin <= 1'b0;
        tick(12);
        @(posedge clk) extIrqPin <= 1'b1;
        n = 0;
        while (vecCnt < 3 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        // Counter register and loop sampling add two clocks to the latency
        chkFlag(n >= 3 * mcu_irq_pkg::INSTR_CLKS + 2 && n <= 4 * mcu_irq_pkg::INSTR_CLKS + 2, 1'b1);
        apb(1'b0, 8'h40, 32'h0);
        chkFlag(err, 1'b1);
        chk(rd, 32'h0);
        @(posedge clk) arstN <= 1'b0;
        tick(2);
        arstN <= 1'b1;
        rdchk(8'h00, 32'h00);
        rdchk(8'h04, 32'hFF);
        rdchk(8'h10, 32'h00);
        final_report();
    end

    initial
    begin
        tick(5000);
        errors++;
        final_report();
    end
endmodule : testbench
